// ===== hw/smx_conv_ctrl.sv
// How it works
// - Latch channel address on strobe rising edge
// - Expansion high selects latched channel of sixteen
// - Expansion low switches all channels off
// - Eight iterations, one bit each, MSB first
// - Trigger rising edge clears approximation register
// - Trigger falling edge starts the approximation
// - New trigger aborts a running conversion
// - Done falls within eight converter clocks
// - Done may feed back to trigger input
// - Result is positive-true binary
// - Result loads one converter clock before done
// - Result pins driven only while gate high
module smx_conv_ctrl
  import smx_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire smx_pin_s pins,
  output logic [CHAN_CNT-1:0] mux_select,
  output logic [SAR_BITS-1:0] ladder_code,
  output logic conversion_done,
  output logic [SAR_BITS-1:0] data_q,
  output logic data_oe_n
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Channel decoder: one enable per analog input
  function automatic logic [CHAN_CNT-1:0] chan_onehot(input logic [3:0] a, input logic en);
    chan_onehot = '0;
    if (en) begin
      chan_onehot[a] = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smx_pin_s pin_s1_r; // First sync stage, read only by stage two
  smx_pin_s pin_s2_r; // Second sync stage, safe to use
  smx_pin_s pin_d_r; // Delayed copy for edge detection
  logic tick; // One converter clock edge
  logic strobe_rise; // Address strobe rising edge
  logic trig_rise; // Trigger rising edge
  logic trig_fall; // Trigger falling edge
  smx_state_e state_r; // Sequencer state
  smx_state_e state_nxt; // Next sequencer state
  logic [3:0] addr_r; // Latched channel address
  logic [SAR_BITS-1:0] sar_r; // Approximation register
  logic [SAR_BITS-1:0] sar_nxt; // Next approximation value
  logic [2:0] bit_r; // Bit under trial
  logic [SAR_BITS-1:0] data_r; // Output data register
  logic done_r; // Conversion done flag
  logic oe_n_r; // Result pin enable, low drives
  logic [CHAN_CNT-1:0] mux_r; // Channel enables
  logic [2:0] iter_r; // Iterations finished, checking only
  logic fresh_r; // Start just taken, comparator not yet settled
  logic decide; // Converter clock edge that decides a bit

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Every pin crosses two flops before any logic sees it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= PIN_RST;
      pin_s2_r <= PIN_RST;
      pin_d_r <= PIN_RST;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // Edges taken only from the settled copies
  assign strobe_rise = pin_s2_r.addr_strobe && !pin_d_r.addr_strobe;
  assign trig_rise = pin_s2_r.conversion_trigger && !pin_d_r.conversion_trigger;
  assign trig_fall = !pin_s2_r.conversion_trigger && pin_d_r.conversion_trigger;

  // ----------------------------------------
  // Converter clock
  // ----------------------------------------
  // Comparator settles for a tick period less the two sync cycles before sampling
  smx_tick_gen #(
    .DIV(DIV)
  ) u_tick (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick)
  );

  // ----------------------------------------
  // Channel address and multiplexer
  // ----------------------------------------
  // Address and strobe share one sync delay, so setup is kept
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= ADDR_RST;
    end else if (strobe_rise) begin
      addr_r <= pin_s2_r.chan_addr;
    end
  end

  // Enables come from a flop so the switches never glitch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mux_r <= '0;
    end else begin
      // Low expansion forces all off, high picks one
      mux_r <= chan_onehot(addr_r, pin_s2_r.expansion_ctl);
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // The first tick after a start may come one cycle after the ladder
  // moved, before the synced comparator follows, so it decides nothing
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fresh_r <= 1'b0;
    end else if (state_r == SMX_ARM && trig_fall) begin
      fresh_r <= 1'b1;
    end else if (tick) begin
      fresh_r <= 1'b0;
    end
  end

  // Costs one converter clock per conversion, buys a settled comparator
  assign decide = tick && !fresh_r;

  // A trigger rise wins over any state, aborting work
  always_comb begin
    state_nxt = state_r;
    if (trig_rise) begin
      state_nxt = SMX_ARM;
    end else begin
      unique case (state_r)
        SMX_IDLE: begin
          state_nxt = SMX_IDLE;
        end
        SMX_ARM: begin
          // Wait for the trigger to drop
          if (trig_fall) begin
            state_nxt = SMX_CONV;
          end
        end
        SMX_CONV: begin
          // Last bit decided ends the trials
          if (decide && bit_r == 3'h0) begin
            state_nxt = SMX_LOAD;
          end
        end
        SMX_LOAD: begin
          if (tick) begin
            state_nxt = SMX_FINISH;
          end
        end
        SMX_FINISH: begin
          if (tick) begin
            state_nxt = SMX_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SMX_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Approximation register
  // ----------------------------------------
  // Comparator high keeps the bit: bigger input, bigger code
  always_comb begin
    sar_nxt = sar_r;
    if (!pin_s2_r.comp_high) begin
      sar_nxt[bit_r] = 1'b0;
    end
    if (bit_r != 3'h0) begin
      sar_nxt[3'(bit_r - 3'h1)] = 1'b1;
    end
  end

  // One bit decided per converter clock, MSB downward
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sar_r <= SAR_RST;
      bit_r <= MSB_IDX;
    end else if (trig_rise) begin
      sar_r <= SAR_RST;
      bit_r <= MSB_IDX;
    end else if (state_r == SMX_ARM && trig_fall) begin
      // First trial sets the MSB alone
      sar_r <= {1'b1, {(SAR_BITS-1){1'b0}}};
      bit_r <= MSB_IDX;
    end else if (state_r == SMX_CONV && decide) begin
      sar_r <= sar_nxt;
      bit_r <= 3'(bit_r - 3'h1);
    end
  end

  // ----------------------------------------
  // Output data register and done flag
  // ----------------------------------------
  // Written only on a completed conversion; aborts leave it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_r <= DATA_RST;
    end else if (state_r == SMX_LOAD && tick && !trig_rise) begin
      data_r <= sar_r;
    end
  end

  // Done drops at once on a trigger rise, well inside the limit.
  // Because done rises only after the result is loaded, it can be
  // wired straight back to the trigger for free-running use.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_r <= DONE_RST;
    end else if (trig_rise) begin
      done_r <= 1'b0;
    end else if (state_r == SMX_FINISH && tick) begin
      done_r <= 1'b1;
    end
  end

  // Result pins follow the synced gate, one flop later
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !pin_s2_r.output_gate;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mux_select = mux_r;
  assign ladder_code = sar_r;
  assign conversion_done = done_r;
  assign data_q = data_r;
  assign data_oe_n = oe_n_r;

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  // Counts deciding converter clocks spent in trials
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      iter_r <= 3'h0;
    end else if (state_r != SMX_CONV) begin
      iter_r <= 3'h0;
    end else if (decide) begin
      iter_r <= 3'(iter_r + 3'h1);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_addr_latch: assert property (strobe_rise |=> addr_r == $past(pin_s2_r.chan_addr))
    else $error("address not latched on strobe");
  a_addr_hold: assert property (!strobe_rise |=> $stable(addr_r))
    else $error("address changed without strobe");
  a_mux_one: assert property (pin_s2_r.expansion_ctl ##1 $stable(addr_r)
      |-> mux_select == (16'h0001 << addr_r))
    else $error("wrong channel enabled");
  a_mux_off: assert property (!pin_s2_r.expansion_ctl |=> mux_select == 16'h0000)
    else $error("channel on with expansion low");
  a_iter_eight: assert property (state_r == SMX_CONV && state_nxt == SMX_LOAD
      |-> iter_r == ITER_LAST)
    else $error("conversion not eight iterations");
  a_sar_clear: assert property (trig_rise |=> sar_r == 8'h00 && state_r == SMX_ARM)
    else $error("register not cleared on trigger rise");
  a_begin_fall: assert property (state_r == SMX_ARM && trig_fall && !trig_rise
      |=> state_r == SMX_CONV && sar_r == 8'h80)
    else $error("conversion not begun on trigger fall");
  a_abort_run: assert property (state_r == SMX_CONV && trig_rise
      |=> state_r == SMX_ARM ##1 !(state_r inside {SMX_LOAD, SMX_FINISH}))
    else $error("running conversion not aborted");
  a_done_low: assert property (trig_rise |=> !conversion_done)
    else $error("done not low after trigger rise");
  a_code_polarity: assert property (state_r == SMX_CONV && decide && !trig_rise
      |=> sar_r[$past(bit_r)] == $past(pin_s2_r.comp_high))
    else $error("result bit not positive-true");
  a_load_lead: assert property ($rose(conversion_done) |-> $past(state_r) == SMX_FINISH
      && $past(data_r) == $past(sar_r))
    else $error("result not loaded before done");
  a_gate_drive: assert property (pin_s2_r.output_gate ##1 pin_s2_r.output_gate
      |-> !data_oe_n)
    else $error("result pins not driven while gated");
  a_done_conv: assert property (state_r inside {SMX_ARM, SMX_CONV, SMX_LOAD}
      |-> !conversion_done)
    else $error("done high during conversion");
  a_data_keep: assert property (!(state_r == SMX_LOAD && tick) |=> $stable(data_q))
    else $error("result changed without completion");

  c_full_conv: cover property ($rose(conversion_done));
  c_abort: cover property (state_r == SMX_CONV && trig_rise);
  c_exp_off: cover property (strobe_rise && !pin_s2_r.expansion_ctl);

endmodule

// ===== shared/smx_pkg.sv
package smx_pkg;

  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  // System clock rate in Hz
  localparam int MCLK_HZ = 10_000_000;
  // Converter clock rate in Hz
  localparam int CONV_CLK_HZ = 640_000;
  // System clocks per converter clock, never below 3
  localparam int CONV_DIV = (MCLK_HZ / CONV_CLK_HZ < 3) ? 3 : MCLK_HZ / CONV_CLK_HZ;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  // Result width
  localparam int SAR_BITS = 8;
  // Channel address width
  localparam int ADDR_W = 4;
  // Number of analog inputs
  localparam int CHAN_CNT = 16;
  // Iterations per conversion
  localparam int ITER_CNT = 8;
  // Index of the first bit decided
  localparam logic [2:0] MSB_IDX = 3'h7;
  // Iteration counter value on the last iteration
  localparam logic [2:0] ITER_LAST = 3'h7;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  // Approximation register after reset
  localparam logic [7:0] SAR_RST = 8'h00;
  // Output data register after reset
  localparam logic [7:0] DATA_RST = 8'h00;
  // Latched address after reset
  localparam logic [3:0] ADDR_RST = 4'h0;
  // Done flag idles high: no conversion is running
  localparam logic DONE_RST = 1'b1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // Control pins, all asynchronous to mclk
  typedef struct packed {
    logic addr_strobe;       // Rising edge latches channel address
    logic [3:0] chan_addr;   // D is bit 3, A is bit 0
    logic expansion_ctl;     // High enables the multiplexer
    logic conversion_trigger; // Rise clears, fall starts
    logic output_gate;       // High drives the result pins
    logic comp_high;         // Comparator: input above ladder tap
  } smx_pin_s;

  // Synchroniser contents after reset
  localparam smx_pin_s PIN_RST = '0;

  // Converter sequencer states
  typedef enum logic [2:0] {
    SMX_IDLE,
    SMX_ARM,
    SMX_CONV,
    SMX_LOAD,
    SMX_FINISH
  } smx_state_e;

endpackage

// ===== hw/smx_tick_gen.sv
module smx_tick_gen
  import smx_pkg::*;
#(
  parameter int DIV = CONV_DIV
) (
  input wire logic mclk,
  input wire logic resetn,
  output logic tick
);

  // ----------------------------------------
  // Converter clock divider
  // ----------------------------------------
  // Width large enough for any sensible divide ratio
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  // Cycle counter within one converter period
  logic [CW-1:0] cnt_r;

  // Free-running count; the converter clock never stops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // One-cycle pulse marks each converter clock edge
  assign tick = (cnt_r == LAST);

endmodule

// ===== sim/smx_analog_model.sv
// ----------------------------------------
// Analog side: input levels and comparator
// ----------------------------------------
module smx_analog_model
  import smx_pkg::*;
(
  input wire logic [CHAN_CNT-1:0] mux_select,
  input wire logic [SAR_BITS-1:0] ladder_code,
  input wire logic [SAR_BITS-1:0] ext_level,
  output logic comp_high
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [SAR_BITS-1:0] lvl; // Level at comparator input

  // Channel n sits at n*0x11; all off means the external level
  always_comb begin
    lvl = ext_level;
    for (int i = 0; i < CHAN_CNT; i++) begin
      if (mux_select[i]) begin
        lvl = 8'(i * 17);
      end
    end
  end

  // Two channels on at once shorts inputs: no usable answer
  always_comb begin
    if ($countones(mux_select) > 1) begin
      comp_high = 1'bx;
    end else begin
      comp_high = (lvl >= ladder_code);
    end
  end
endmodule

// ===== sim/sar_adc_mux_control_bench.sv
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module sar_adc_mux_control_bench
  import smx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int SDIV = 3; // Short converter clock keeps runs brief
  logic mclk;
  logic resetn;
  logic stb;
  logic expn;
  logic trig;
  logic gate;
  logic fr; // Done wired back to trigger
  logic cmp;
  logic [3:0] addr;
  logic [7:0] ext_lvl;
  logic [15:0] mux;
  logic [7:0] ladder;
  logic [7:0] data;
  logic done;
  logic oe_n;
  logic [7:0] hist [8]; // Recent data_q samples, newest first
  smx_pin_s pins;
  int error_cnt;
  int total_checks;

  assign pins = '{addr_strobe: stb, chan_addr: addr, expansion_ctl: expn,
    conversion_trigger: fr ? done : trig, output_gate: gate, comp_high: cmp};

  smx_conv_ctrl #(.DIV(SDIV)) dut_u (.mclk(mclk), .resetn(resetn), .pins(pins),
    .mux_select(mux), .ladder_code(ladder), .conversion_done(done), .data_q(data),
    .data_oe_n(oe_n));
  smx_analog_model model_u (.mux_select(mux), .ladder_code(ladder), .ext_level(ext_lvl),
    .comp_high(cmp));

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Advance past edges, keeping a short history of the result
  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #10;
      for (int j = 7; j > 0; j--) hist[j] = hist[j-1];
      hist[0] = data;
    end
  endtask

  // Bounded wait for done to reach a level
  task automatic wait_done(input logic lvl, input int lim);
    int k;
    k = 0;
    while (done !== lvl && k < lim) begin
      step(1);
      k++;
    end
  endtask

  task automatic sel(input logic [3:0] ch);
    addr = ch;
    step(3);
    stb = 1'b1;
    step(4);
    `CHK("mux_select", 16'h0001 << ch, mux)
    stb = 1'b0;
    step(3);
    addr = ~ch;
    step(5);
    `CHK("mux_hold", 16'h0001 << ch, mux)
    addr = ch;
  endtask

  // Rise acts on the third edge; done may already be low mid-run,
  // so wait the fixed sync latency rather than for done to drop
  task automatic rise();
    trig = 1'b1;
    step(3);
    `CHK("done_fall", 1'b0, done)
    `CHK("sar_clear", 8'h00, ladder)
    // Trigger is async to the converter clock: eight clocks plus 2 us
    step(8 * SDIV + 20);
  endtask

  task automatic fall();
    int k;
    trig = 1'b0;
    k = 0;
    while (ladder === 8'h00 && k < 6) begin
      step(1);
      k++;
    end
    `CHK("sar_start", 8'h80, ladder)
  endtask

  task automatic finish(input logic [7:0] ex, input logic [7:0] prev);
    wait_done(1'b1, 20 * SDIV);
    `CHK("done_rise", 1'b1, done)
    `CHK("result", ex, data)
    `CHK("load_early", ex, hist[SDIV])
    if (ex !== prev) `CHK("load_late", prev, hist[SDIV+1])
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic all_channels();
    logic [7:0] prev;
    for (int c = 0; c < 16; c++) begin
      prev = data;
      sel(4'(c));
      rise();
      fall();
      finish(8'(c * 17), prev);
    end
  endtask

  task automatic expansion_off();
    expn = 1'b0;
    step(3);
    `CHK("mux_off", 16'h0000, mux)
    ext_lvl = 8'hA5;
    rise();
    fall();
    finish(8'hA5, 8'hFF);
    expn = 1'b1;
  endtask

  task automatic gate_chk();
    gate = 1'b1;
    step(2);
    `CHK("oe_n_early", 1'b1, oe_n)
    step(1);
    `CHK("oe_n_on", 1'b0, oe_n)
    gate = 1'b0;
    step(3);
    `CHK("oe_n_off", 1'b1, oe_n)
  endtask

  // Retrigger mid-run: old result must survive the aborted run
  task automatic abort_chk();
    sel(4'h2);
    rise();
    fall();
    step(4 * SDIV);
    rise();
    `CHK("abort_keep", 8'hA5, data)
    fall();
    finish(8'h22, 8'hA5);
  endtask

  // One host pulse, then done drives the trigger
  task automatic free_run();
    sel(4'h5);
    trig = 1'b1;
    step(8 * SDIV + 20);
    fr = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_done(1'b1, 20 * SDIV);
      `CHK("free_result", 8'h55, data)
      wait_done(1'b0, 8 * SDIV);
      `CHK("free_restart", 1'b0, done)
    end
    fr = 1'b0;
    trig = 1'b0;
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles
  initial begin
    #(100 * 20000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    resetn = 1'b0;
    {stb, trig, gate, fr, addr, ext_lvl} = '0;
    expn = 1'b1;
    error_cnt = 0;
    total_checks = 0;
    repeat (3) @(posedge mclk);
    #10;
    `CHK("rst_done", 1'b1, done)
    `CHK("rst_oe_n", 1'b1, oe_n)
    resetn = 1'b1;
    step(2);
    all_channels();
    gate_chk();
    expansion_off();
    abort_chk();
    free_run();
    wrap_up();
  end
endmodule
